// ---- hdl/secure_flash_program_cmd.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Command frame: start byte, length 27h, code 41h, addresses, codes, sum, ETX.
// - Both addresses arrive as three bytes, low byte first.
// - Two 16-byte secure codes are held as secure data during the write.
// - Start above end gives a parameter error and back to command wait.
// - Address outside both flash regions gives a parameter error.
// - A range crossing a region boundary gives a parameter error.
// - Range must start and end exactly on block boundaries.
// - Valid parameters answer STX, 01h, 06h, F9h, ETX.
// - While awaiting data, non-STX bytes are dropped; STX opens a packet.
// - Wrong terminator for last or non-last packet sets NACK.
// - Checksum mismatch sets the checksum error status.
// - Wrong data length byte sets NACK.
// - Too much or too little data for the range sets NACK.
// - Error on the first packet answers and quits with flash untouched.
// - Later packets report the previous write outcome, then quit on error.
// - Data answer carries two statuses; clean answer is 02h, 06h, 06h, F2h.
// - Non-last packet: acknowledge, write, then take the next packet.
// - Last packet: write first, answer only after the write outcome.
// - Verification runs only after a clean last write; its faults give one-status answers.
// - Clean verification acknowledges and returns to command wait.
// - Command in a forbidden phase answers a command number error.
module secure_flash_program_cmd (
  input wire logic core_clk,
  input wire logic rst,
  input wire secprog_pkg::byte_t rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output secprog_pkg::byte_t tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic cmd_permitted,
  output logic cmd_wait,
  output logic flash_start,
  output secprog_pkg::addr_t flash_page_addr,
  input wire secprog_pkg::byte_t flash_rd_idx,
  output secprog_pkg::byte_t flash_rd_byte,
  input wire logic flash_done,
  input wire logic security_fault,
  input wire logic write_fault_flag,
  input wire logic sequencer_fault_flag,
  output logic verify_start,
  input wire logic verify_done,
  input wire logic verify_fault_flag,
  output logic secure_valid,
  output logic [127:0] secure_code_one,
  output logic [127:0] secure_code_two
);
  import secprog_pkg::*;

  state_t state_q, state_d, after_q, after_d;
  logic [8:0] cnt_q;
  byte_t sum_q, len_q, cmd_q;
  addr_t sa_q, ea_q, page_addr_q, page_addr_d;
  logic [255:0] code_q;
  byte_t page_mem [256];
  byte_t resp_len_q, resp_len_d, st0_q, st0_d, st1_q, st1_d, prev_ws_q, prev_ws_d;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic [16:0] pk_left_q, pk_left_d;
  logic first_q, first_d, last_q, last_d, sec_valid_q, sec_valid_d;
  logic flash_start_q, verify_start_q;
  byte_t flash_rd_byte_q;

  // Receive side decode; bytes come from same-clock logic, so no synchroniser.
  wire in_rx = (state_q == S_CMD_RX) || (state_q == S_DATA_RX);
  wire hunting = (state_q == S_IDLE) || (state_q == S_DATA_WAIT);
  assign rx_ready = in_rx || hunting;
  wire rx_fire = rx_valid && rx_ready;
  wire start_fire = rx_fire && ((state_q == S_IDLE && rx_data == SOH) ||
                                (state_q == S_DATA_WAIT && rx_data == STX));
  wire [8:0] body_len = (len_q == 8'h00) ? BODY_FULL : {1'b0, len_q};
  wire [8:0] end_idx = body_len + FRAME_TAIL;
  wire pkt_end = in_rx && rx_fire && (cnt_q > IDX_LEN) && (cnt_q == end_idx);
  wire sum_ok = (sum_q == 8'h00);
  wire is_cmd = (state_q == S_CMD_RX);
  wire is_sa = is_cmd && cnt_q >= IDX_SA && cnt_q < IDX_EA;
  wire is_ea = is_cmd && cnt_q >= IDX_EA && cnt_q < IDX_CODE;
  wire is_code = is_cmd && cnt_q >= IDX_CODE && cnt_q < IDX_CODE_END;
  wire [8:0] data_off = cnt_q - IDX_DATA;
  wire mem_we = (state_q == S_DATA_RX) && rx_fire && cnt_q >= IDX_DATA &&
                cnt_q < IDX_DATA_END && cnt_q + 9'h001 < end_idx;

  // Parameter checks on the captured range.
  wire sa_cf = sa_q >= CF_START && sa_q <= CF_END;
  wire sa_df = sa_q >= DF_START && sa_q <= DF_END;
  wire ea_cf = ea_q >= CF_START && ea_q <= CF_END;
  wire ea_df = ea_q >= DF_START && ea_q <= DF_END;
  wire p_order = sa_q > ea_q;
  wire p_out = !(sa_cf || sa_df) || !(ea_cf || ea_df);
  wire p_cross = sa_cf != ea_cf;
  wire p_align = (sa_q[BLOCK_BITS-1:0] != '0) || !(&ea_q[BLOCK_BITS-1:0]);
  wire param_bad = p_order || p_out || p_cross || p_align;
  wire [24:0] span = {1'b0, ea_q} - {1'b0, sa_q} + 25'h000_0001;
  wire [16:0] pk_total = span[24:8];

  // Command verdict in priority order: framing, sum, phase, then range.
  wire cmd_frame_bad = (rx_data != ETX) || (len_q != LEN_CMD);
  wire byte_t cmd_st = cmd_frame_bad ? ST_NACK :
                       !sum_ok ? ST_CKSUM :
                       !cmd_permitted ? ST_CMDNUM :
                       param_bad ? ST_PARAM : ST_ACK;
  wire cmd_ok = (cmd_st == ST_ACK);

  // Data verdict; the expected terminator also catches too much or too little data.
  wire want_last = (pk_left_q == 17'h0_0001);
  wire term_bad = want_last ? (rx_data != ETX) : (rx_data != ETB);
  wire byte_t comm_st = term_bad ? ST_NACK :
                        (len_q != LEN_DATA) ? ST_NACK :
                        !sum_ok ? ST_CKSUM : ST_ACK;
  wire data_bad = (comm_st != ST_ACK) || (prev_ws_q != ST_ACK);

  // Outcome of the secure driver and flash sequencer.
  wire byte_t w_st = security_fault ? ST_SECSYS :
                     write_fault_flag ? ST_WRITE :
                     sequencer_fault_flag ? ST_PROTECT : ST_ACK;
  wire byte_t v_st = verify_fault_flag ? ST_IVERIFY :
                     sequencer_fault_flag ? ST_PROTECT : ST_ACK;

  // Response framer feeding the output buffer.
  wire two_st = (resp_len_q == LEN_TWO);
  wire byte_t tx_sum = 8'h00 - resp_len_q - st0_q - (two_st ? st1_q : 8'h00);
  wire [2:0] tx_last = two_st ? 3'h5 : 3'h4;
  wire byte_t tx_byte = (tx_idx_q == 3'h0) ? STX :
                        (tx_idx_q == 3'h1) ? resp_len_q :
                        (tx_idx_q == 3'h2) ? st0_q :
                        (tx_idx_q == 3'h3) ? (two_st ? st1_q : tx_sum) :
                        (tx_idx_q == 3'h4) ? (two_st ? tx_sum : ETX) : ETX;
  wire buf_in_valid = (state_q == S_TX);
  logic buf_in_ready;
  wire buf_fire = buf_in_valid && buf_in_ready;

  // A stall by the receiver only holds the framer; no answer byte is dropped.
  byte_buffer2 #(
    .W(8),
    .DEPTH(2)
  ) u_tx_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(tx_byte),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .out_data(tx_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // Sequencer of the whole command, from command wait back to command wait.
  always_comb begin
    state_d = state_q;
    after_d = after_q;
    resp_len_d = resp_len_q;
    st0_d = st0_q;
    st1_d = st1_q;
    tx_idx_d = tx_idx_q;
    first_d = first_q;
    last_d = last_q;
    pk_left_d = pk_left_q;
    page_addr_d = page_addr_q;
    prev_ws_d = prev_ws_q;
    sec_valid_d = sec_valid_q;
    case (state_q)
      S_IDLE: begin
        if (start_fire) begin
          state_d = S_CMD_RX;
        end
      end
      S_CMD_RX: begin
        if (pkt_end) begin
          if (cmd_q != CMD_SECPROG) begin
            state_d = S_IDLE;
          end else begin
            state_d = S_TX;
            after_d = cmd_ok ? S_DATA_WAIT : S_IDLE;
            resp_len_d = LEN_ONE;
            st0_d = cmd_st;
            first_d = 1'b1;
            last_d = 1'b0;
            pk_left_d = pk_total;
            page_addr_d = sa_q;
            prev_ws_d = ST_ACK;
            sec_valid_d = cmd_ok;
          end
        end
      end
      S_DATA_WAIT: begin
        if (start_fire) begin
          state_d = S_DATA_RX;
        end
      end
      S_DATA_RX: begin
        if (pkt_end) begin
          resp_len_d = LEN_TWO;
          st0_d = comm_st;
          st1_d = prev_ws_q;
          if (data_bad) begin
            state_d = S_TX;
            after_d = S_IDLE;
          end else if (!want_last) begin
            state_d = S_TX;
            after_d = S_WRITE;
          end else begin
            state_d = S_WRITE;
            last_d = 1'b1;
          end
        end
      end
      S_WRITE: begin
        if (flash_done) begin
          page_addr_d = page_addr_q + PAGE_STEP;
          pk_left_d = pk_left_q - 17'h0_0001;
          first_d = 1'b0;
          if (!last_q) begin
            prev_ws_d = w_st;
            state_d = S_DATA_WAIT;
          end else begin
            state_d = S_TX;
            resp_len_d = LEN_TWO;
            st0_d = ST_ACK;
            st1_d = w_st;
            after_d = (w_st == ST_ACK) ? S_VERIFY : S_IDLE;
          end
        end
      end
      S_VERIFY: begin
        if (verify_done) begin
          state_d = S_TX;
          resp_len_d = LEN_ONE;
          st0_d = v_st;
          after_d = S_IDLE;
        end
      end
      S_TX: begin
        if (buf_fire) begin
          tx_idx_d = tx_idx_q + 3'h1;
          if (tx_idx_q == tx_last) begin
            tx_idx_d = 3'h0;
            state_d = after_q;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (state_d == S_IDLE) begin
      sec_valid_d = 1'b0;
    end
  end

  // Control registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      after_q <= S_IDLE;
      resp_len_q <= LEN_ONE;
      st0_q <= ST_ACK;
      st1_q <= ST_ACK;
      tx_idx_q <= 3'h0;
      first_q <= 1'b0;
      last_q <= 1'b0;
      pk_left_q <= PAGES_RST;
      page_addr_q <= '0;
      prev_ws_q <= ST_ACK;
      sec_valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      after_q <= after_d;
      resp_len_q <= resp_len_d;
      st0_q <= st0_d;
      st1_q <= st1_d;
      tx_idx_q <= tx_idx_d;
      first_q <= first_d;
      last_q <= last_d;
      pk_left_q <= pk_left_d;
      page_addr_q <= page_addr_d;
      prev_ws_q <= prev_ws_d;
      sec_valid_q <= sec_valid_d;
    end
  end

  // Byte position and running sum; the sum covers length through checksum.
  always_ff @(posedge core_clk) begin
    if (rst || start_fire) begin
      cnt_q <= {8'h00, start_fire};
      sum_q <= 8'h00;
    end else if (in_rx && rx_fire) begin
      cnt_q <= cnt_q + 9'h001;
      sum_q <= sum_q + rx_data;
    end
  end

  // Field capture; addresses shift in from the top so the low byte lands lowest.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      len_q <= 8'h00;
      cmd_q <= 8'h00;
      sa_q <= '0;
      ea_q <= '0;
      code_q <= '0;
    end else if (in_rx && rx_fire) begin
      len_q <= (cnt_q == IDX_LEN) ? rx_data : len_q;
      cmd_q <= (is_cmd && cnt_q == IDX_CMD) ? rx_data : cmd_q;
      sa_q <= is_sa ? {rx_data, sa_q[23:8]} : sa_q;
      ea_q <= is_ea ? {rx_data, ea_q[23:8]} : ea_q;
      code_q <= is_code ? {code_q[247:0], rx_data} : code_q;
    end
  end

  // Page buffer; flash is only touched after the packet has been judged.
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      page_mem[data_off[7:0]] <= rx_data;
    end
  end

  // Start strobes fire on entry to the write and verify steps.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flash_start_q <= 1'b0;
      verify_start_q <= 1'b0;
      flash_rd_byte_q <= 8'h00;
    end else begin
      flash_start_q <= (state_d == S_WRITE) && (state_q != S_WRITE);
      verify_start_q <= (state_d == S_VERIFY) && (state_q != S_VERIFY);
      flash_rd_byte_q <= page_mem[flash_rd_idx];
    end
  end

  assign cmd_wait = (state_q == S_IDLE);
  assign flash_start = flash_start_q;
  assign verify_start = verify_start_q;
  assign flash_page_addr = page_addr_q;
  assign flash_rd_byte = flash_rd_byte_q;
  assign secure_valid = sec_valid_q;
  assign secure_code_one = code_q[255:128];
  assign secure_code_two = code_q[127:0];

  // Checks on the answers the block produces.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire cmd_end = is_cmd && pkt_end && cmd_q == CMD_SECPROG && !cmd_frame_bad && sum_ok;
  property p_order_err;
    cmd_end && cmd_permitted && p_order |=> st0_q == ST_PARAM && after_q == S_IDLE;
  endproperty
  a_order_err: assert property (p_order_err) else $error("bad order not refused");
  property p_drop_noise;
    state_q == S_DATA_WAIT && rx_valid && rx_data != STX |=> state_q == S_DATA_WAIT;
  endproperty
  a_drop_noise: assert property (p_drop_noise) else $error("noise opened packet");
  property p_sum_one;
    buf_fire && !two_st && st0_q == ST_ACK && tx_idx_q == 3'h3 |-> tx_byte == SUM_ACK_ONE;
  endproperty
  a_sum_one: assert property (p_sum_one) else $error("wrong one-status sum");
  property p_sum_two;
    buf_fire && two_st && st0_q == ST_ACK && st1_q == ST_ACK && tx_idx_q == 3'h4
      |-> tx_byte == SUM_ACK_TWO;
  endproperty
  a_sum_two: assert property (p_sum_two) else $error("wrong two-status sum");
  property p_first_quit;
    state_q == S_DATA_RX && pkt_end && first_q && comm_st != ST_ACK
      |=> state_q == S_TX && after_q == S_IDLE ##1 !flash_start_q [*4];
  endproperty
  a_first_quit: assert property (p_first_quit) else $error("first error not final");
  property p_ack_then_write;
    state_q == S_DATA_RX && pkt_end && !data_bad && !want_last
      |=> state_q == S_TX && after_q == S_WRITE && !flash_start_q;
  endproperty
  a_ack_then_write: assert property (p_ack_then_write) else $error("write before ack");
  property p_last_write;
    state_q == S_DATA_RX && pkt_end && !data_bad && want_last
      |=> state_q == S_WRITE && flash_start_q && !tx_valid;
  endproperty
  a_last_write: assert property (p_last_write) else $error("last write not started");
  property p_prev_fault;
    state_q == S_WRITE && flash_done && !last_q && write_fault_flag && !security_fault
      |=> prev_ws_q == ST_WRITE;
  endproperty
  a_prev_fault: assert property (p_prev_fault) else $error("write fault not kept");
  property p_verify_fault;
    state_q == S_VERIFY && verify_done && verify_fault_flag
      |=> st0_q == ST_IVERIFY && resp_len_q == LEN_ONE;
  endproperty
  a_verify_fault: assert property (p_verify_fault) else $error("verify fault lost");
  property p_phase_err;
    cmd_end && !cmd_permitted |=> st0_q == ST_CMDNUM;
  endproperty
  a_phase_err: assert property (p_phase_err) else $error("phase error missed");
  c_cmd_ack: cover property (cmd_end && cmd_ok);
  c_page_ack: cover property (state_q == S_WRITE && flash_done && !last_q);
  c_verify_ok: cover property (state_q == S_VERIFY && verify_done && v_st == ST_ACK);
endmodule : secure_flash_program_cmd

// ---- inc/secprog_pkg.sv ----
package secprog_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [23:0] addr_t;
  // Framing bytes.
  localparam byte_t SOH = 8'h01;
  localparam byte_t STX = 8'h02;
  localparam byte_t ETX = 8'h03;
  localparam byte_t ETB = 8'h17;
  localparam byte_t LEN_CMD = 8'h27;
  localparam byte_t CMD_SECPROG = 8'h41;
  localparam byte_t LEN_DATA = 8'h00;
  localparam byte_t LEN_ONE = 8'h01;
  localparam byte_t LEN_TWO = 8'h02;
  localparam byte_t SUM_ACK_ONE = 8'hF9;
  localparam byte_t SUM_ACK_TWO = 8'hF2;
  // Status codes; only the acknowledge value is fixed by the protocol.
  localparam byte_t ST_ACK = 8'h06;
  localparam byte_t ST_NACK = 8'h15;
  localparam byte_t ST_CKSUM = 8'h07;
  localparam byte_t ST_CMDNUM = 8'h04;
  localparam byte_t ST_PARAM = 8'h05;
  localparam byte_t ST_PROTECT = 8'h10;
  localparam byte_t ST_WRITE = 8'h1C;
  localparam byte_t ST_SECSYS = 8'h1A;
  localparam byte_t ST_IVERIFY = 8'h1B;
  // Flash regions and block geometry.
  localparam addr_t CF_START = 24'h00_0000;
  localparam addr_t CF_END = 24'h00_FFFF;
  localparam addr_t DF_START = 24'h0F_1000;
  localparam addr_t DF_END = 24'h0F_1FFF;
  localparam int BLOCK_BITS = 10;
  // Byte positions inside a frame; position 0 is the start byte.
  localparam logic [8:0] IDX_LEN = 9'h001;
  localparam logic [8:0] IDX_CMD = 9'h002;
  localparam logic [8:0] IDX_SA = 9'h003;
  localparam logic [8:0] IDX_EA = 9'h006;
  localparam logic [8:0] IDX_CODE = 9'h009;
  localparam logic [8:0] IDX_CODE_END = 9'h029;
  localparam logic [8:0] IDX_DATA = 9'h002;
  localparam logic [8:0] IDX_DATA_END = 9'h102;
  localparam logic [8:0] FRAME_TAIL = 9'h003;
  localparam logic [8:0] BODY_FULL = 9'h100;
  localparam logic [23:0] PAGE_STEP = 24'h00_0100;
  localparam logic [16:0] PAGES_RST = 17'h0_0000;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_CMD_RX = 7'h02,
    S_DATA_WAIT = 7'h04,
    S_DATA_RX = 7'h08,
    S_WRITE = 7'h10,
    S_VERIFY = 7'h20,
    S_TX = 7'h40
  } state_t;
endpackage : secprog_pkg

// ---- hdl/byte_buffer2.sv ----
`timescale 1ns/1ps
module byte_buffer2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Sized at the count's width so that the depth itself is not cut to zero.
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // Full and empty come straight from the count, so a stalled reader really fills it.
  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  // Storage carries no reset; the count alone decides what is valid.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  // Pointers wrap on the power-of-two depth.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_buffer2

// ---- test/flash_side_model.sv ----
`timescale 1ns/1ps
module flash_side_model (
  input wire logic core_clk,
  input wire logic flash_start,
  output secprog_pkg::byte_t flash_rd_idx,
  input wire secprog_pkg::byte_t flash_rd_byte,
  output logic flash_done,
  output logic security_fault,
  output logic write_fault_flag,
  output logic sequencer_fault_flag,
  input wire logic verify_start,
  output logic verify_done,
  output logic verify_fault_flag,
  output logic tx_ready,
  input wire logic [2:0] fault,
  output secprog_pkg::byte_t page_sum
);
  import secprog_pkg::*;
  logic [3:0] cnt_q = 4'h0;
  // The receiver stalls four cycles in sixteen, so the answer buffer must hold.
  always @(posedge core_clk) cnt_q <= cnt_q + 4'h1;
  assign tx_ready = cnt_q[3:2] != 2'h3;
  // Writer reads the whole page before finishing; faults ride on the done pulse only.
  initial begin : seq
    byte_t s;
    {flash_done, verify_done, security_fault, write_fault_flag} = '0;
    {sequencer_fault_flag, verify_fault_flag, flash_rd_idx, page_sum} = '0;
    forever begin
      @(posedge core_clk);
      if (flash_start || verify_start) begin
        if (flash_start) begin
          s = 8'h00;
          for (int i = 0; i < 256; i++) begin
            flash_rd_idx <= byte_t'(i);
            repeat (2) @(posedge core_clk);
            s += flash_rd_byte;
          end
          page_sum <= s;
          flash_done <= 1'b1;
          write_fault_flag <= fault == 3'h1;
          security_fault <= fault == 3'h4;
        end else begin
          repeat (20) @(posedge core_clk);
          verify_done <= 1'b1;
          verify_fault_flag <= fault == 3'h2;
          sequencer_fault_flag <= fault == 3'h3;
        end
        @(posedge core_clk);
        {flash_done, verify_done, security_fault, write_fault_flag} <= '0;
        {sequencer_fault_flag, verify_fault_flag} <= '0;
      end
    end
  end
endmodule : flash_side_model

// ---- test/tb_secure_flash_program_cmd.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_secure_flash_program_cmd;
  import secprog_pkg::*;
  localparam logic [127:0] CODE_A = 128'h0123_4567_89AB_CDEF_F0F1_F2F3_F4F5_F6F7;
  localparam logic [127:0] CODE_B = 128'hFEDC_BA98_7654_3210_0F1E_2D3C_4B5A_6978;
  // Host gap after an answer, scaled down from microseconds so the run stays short.
  localparam int GAP = 64;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  byte_t rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic cmd_permitted = 1'b1;
  logic [2:0] fault = 3'h0;
  logic rx_ready, tx_valid, tx_ready, cmd_wait, flash_start, flash_done, security_fault;
  logic write_fault_flag, sequencer_fault_flag, verify_start, verify_done, verify_fault_flag;
  logic secure_valid;
  logic [127:0] secure_code_one, secure_code_two;
  byte_t tx_data, flash_rd_idx, flash_rd_byte, page_sum, psum, et, ews;
  byte_t rnd = 8'h07;
  addr_t flash_page_addr;
  byte_t txq[$];
  logic [31:0] fq[$];
  logic [31:0] ef;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2.5 core_clk = ~core_clk;

  secure_flash_program_cmd i_secure_flash_program_cmd (.core_clk, .rst, .rx_data, .rx_valid,
    .rx_ready, .tx_data, .tx_valid, .tx_ready, .cmd_permitted, .cmd_wait, .flash_start,
    .flash_page_addr, .flash_rd_idx, .flash_rd_byte, .flash_done, .security_fault,
    .write_fault_flag, .sequencer_fault_flag, .verify_start, .verify_done, .verify_fault_flag,
    .secure_valid, .secure_code_one, .secure_code_two);

  flash_side_model i_flash_side_model (.core_clk, .flash_start, .flash_rd_idx, .flash_rd_byte,
    .flash_done, .security_fault, .write_fault_flag, .sequencer_fault_flag, .verify_start,
    .verify_done, .verify_fault_flag, .tx_ready, .fault, .page_sum);

  function automatic byte_t nxt(byte_t v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt

  // Answer bytes and finished pages are matched against the oldest note; a hang ends the run.
  always @(posedge core_clk) begin
    cyc++;
    if (tx_valid === 1'b1 && tx_ready) begin
      et = (txq.size() > 0) ? txq.pop_front() : 8'hxx;
      `CHK(tx_data, et)
    end
    if (flash_done === 1'b1) begin
      ef = (fq.size() > 0) ? fq.pop_front() : 'x;
      `CHK({flash_page_addr, page_sum}, ef)
    end
    if (cyc == 80000) begin
      bad_count++;
      end_sim();
    end
  end

  // The byte is held until the edge that takes it; the line then shows its inverse.
  task automatic send(byte_t b);
    @(posedge core_clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    do @(negedge core_clk); while (rx_ready !== 1'b1);
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send

  task automatic frame(byte_t h, byte_t l, byte_t body[$], byte_t t, byte_t bad);
    byte_t s;
    s = l;
    send(h);
    send(l);
    foreach (body[i]) begin
      send(body[i]);
      s += body[i];
    end
    send(byte_t'(-s) ^ bad);
    send(t);
  endtask : frame

  task automatic cmd(addr_t sa, addr_t ea, byte_t code = CMD_SECPROG);
    byte_t b[$];
    b = {code, sa[7:0], sa[15:8], sa[23:16], ea[7:0], ea[15:8], ea[23:16]};
    for (int i = 15; i >= 0; i--) b.push_back(CODE_A[i*8+:8]);
    for (int i = 15; i >= 0; i--) b.push_back(CODE_B[i*8+:8]);
    frame(SOH, LEN_CMD, b, ETX, 8'h00);
  endtask : cmd

  // Random page data, with a stray byte ahead of the start byte.
  task automatic pkt(byte_t t, byte_t bad = 8'h00);
    byte_t b[$];
    psum = 8'h00;
    for (int i = 0; i < 256; i++) begin
      rnd = nxt(rnd);
      b.push_back(rnd);
      psum += rnd;
    end
    send(8'h55);
    repeat (GAP) @(posedge core_clk);
    frame(STX, LEN_DATA, b, t, bad);
  endtask : pkt

  task automatic resp(byte_t st[$]);
    byte_t s;
    s = byte_t'(st.size());
    txq.push_back(STX);
    txq.push_back(s);
    foreach (st[i]) begin
      txq.push_back(st[i]);
      s += st[i];
    end
    txq.push_back(byte_t'(-s));
    txq.push_back(ETX);
  endtask : resp

  task automatic settle();
    while (txq.size() > 0) @(posedge core_clk);
    repeat (4) @(negedge core_clk);
    `CHK(cmd_wait, 1'b1)
    `CHK(secure_valid, 1'b0)
    `CHK(fq.size(), 0)
    $display("test done at %0t", $time);
  endtask : settle

  task automatic perr(addr_t sa, addr_t ea);
    resp({ST_PARAM});
    cmd(sa, ea);
    settle();
  endtask : perr

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    perr(24'h00_0400, 24'h00_03FF);
    perr(24'h01_0000, 24'h01_03FF);
    perr(24'h00_FC00, 24'h0F_13FF);
    perr(24'h00_0100, 24'h00_03FF);
    @(posedge core_clk);
    cmd_permitted <= 1'b0;
    resp({ST_CMDNUM});
    cmd(24'h00_0000, 24'h00_03FF);
    settle();
    @(posedge core_clk);
    cmd_permitted <= 1'b1;
    cmd(24'h00_0000, 24'h00_03FF, 8'h42);
    settle();
    resp({ST_ACK});
    resp({ST_CKSUM, ST_ACK});
    cmd(24'h00_0000, 24'h00_03FF);
    pkt(ETB, 8'h01);
    settle();
    resp({ST_ACK});
    resp({ST_NACK, ST_ACK});
    cmd(24'h00_0000, 24'h00_03FF);
    pkt(ETX);
    settle();
    resp({ST_ACK});
    resp({ST_NACK, ST_ACK});
    cmd(24'h00_0000, 24'h00_03FF);
    frame(STX, 8'h01, {8'hA5}, ETB, 8'h00);
    settle();
    // Clean run, write, verify, sequencer and security faults, then data past the range.
    for (int m = 0; m < 6; m++) begin
      @(posedge core_clk);
      fault <= 3'(m);
      resp({ST_ACK});
      cmd(24'h00_0000, 24'h00_03FF);
      repeat (3) @(negedge core_clk);
      `CHK({secure_valid, secure_code_one, secure_code_two}, {1'b1, CODE_A, CODE_B})
      for (int p = 0; p < 4; p++) begin
        if ((p == 1 && (m == 1 || m == 4)) || (p == 3 && m == 5)) begin
          ews = (m == 1) ? ST_WRITE : (m == 4) ? ST_SECSYS : ST_ACK;
          resp({(m == 5) ? ST_NACK : ST_ACK, ews});
          pkt(ETB);
          break;
        end
        resp({ST_ACK, ST_ACK});
        if (p == 3) resp({(m == 2) ? ST_IVERIFY : (m == 3) ? ST_PROTECT : ST_ACK});
        pkt((p == 3) ? ETX : ETB);
        fq.push_back({addr_t'(p) << 8, psum});
      end
      settle();
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      `CHK({tx_valid, rx_ready, cmd_wait, secure_valid, flash_start}, 5'h0C)
    end
    end_sim();
  end
endmodule : tb_secure_flash_program_cmd
